// >>> rsd_cfg_bank.sv
/*
 * rsd_cfg_bank: AXI4-Lite configuration bank for the receive control path.
 * Assumes demodulator bits, filter outputs and clock ticks come from logic
 * on sys_clk; readback words are supplied by the measurement blocks.
 */
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - hold 24-bit pattern, compare bit stream
// - lock pin rises on match in receive
// - lock pin falls after nine bits
// - trigger bit write starts filter calibration
// - reduced gain blocks top amplifier step
// - top gain only when reduced cleared
// - signal strength readback valid in receive
// - adc off in transmit unless powered
// - frequency readback needs linear or correlator
// - matching select resets to zero, then follows reg8 bit 12
// - test dac sigma-delta drives clock pin
// - dac on recovery clock, divider check
// - test modes seven and ten enable
// - dac fed by selected demodulator
// - offset over 4096, then power gain
module rsd_cfg_bank import rsd_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// receive datapath
	input  wire logic        rx_bit,
	input  wire logic        rx_bit_en,
	input  wire logic [15:0] lin_filt,
	input  wire logic [15:0] corr_filt,
	input  wire logic        recovery_clock,
	// measurement words
	input  wire logic [15:0] afc_word,
	input  wire logic [15:0] rssi_word,
	input  wire logic [15:0] adc_word,
	input  wire logic [15:0] cal_word,
	// control outputs
	output logic             int_lock_pin,
	output logic             clock_output_pin,
	output logic             filter_cal_start,
	output logic [1:0]       lna_gain_code,
	output logic             matching_select,
	output logic             adc_powered,
	output logic             recovery_enable,
	output logic [15:0]      afc_scale
);
	// ----------------------------------------
	// function
	// ----------------------------------------
	// clamp a wide value to signed 16 bits
	function automatic logic [15:0] sat16(input logic signed [47:0] x);
		if (x > 48'sh7fff) sat16 = 16'h7fff;
		else if (x < -48'sh8000) sat16 = 16'h8000;
		else sat16 = x[15:0];
	endfunction

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [31:0] regs_ff [16];  // one word per select code
	logic [7:0]  awaddr_ff;     // latched write address
	logic        aw_have_ff;    // address held
	logic [31:0] wdata_ff;      // latched write data
	logic [3:0]  wstrb_ff;      // latched strobes
	logic        w_have_ff;     // data held
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        cal_ff;        // one-cycle calibration pulse
	logic [1:0]  lna_ff;
	logic        match_ff;
	logic        adcpu_ff;
	logic        recen_ff;
	logic [15:0] afcs_ff;
	logic        clock_output_pin_ff;
	logic [3:0]  pe_cnt_ff;     // recovery ticks in current bit

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire        wr_fire  = aw_have_ff && w_have_ff && !bvalid_ff;
	wire        wr_ok    = (awaddr_ff == ADDR_CFG) && (wstrb_ff == 4'hf);
	wire        wr_do    = wr_fire && wr_ok;
	wire [3:0]  wr_sel   = wdata_ff[3:0];

	// ----------------------------------------
	// field views
	// ----------------------------------------
	wire        rx_mode  = regs_ff[R_MODE][RX_BIT];
	wire [7:0]  cdr_div  = regs_ff[R_RXCLK][CDR_DIV_LO +: 8];
	wire [2:0]  setup    = regs_ff[R_DEMOD][SETUP_LO +: 3];
	wire [1:0]  dsel     = regs_ff[R_DEMOD][DSEL_LO +: 2];
	wire [23:0] sync_pat = regs_ff[R_SYNC][SYNC_LO +: 24];
	wire        reduced  = regs_ff[R_CORR][RED_BIT];
	wire [1:0]  rb_sel   = regs_ff[R_RDBK][RBSEL_LO +: 2];
	wire        adc_req  = regs_ff[R_PWR][ADCPU_BIT];
	wire        agc_on   = regs_ff[R_AGC][AGCEN_BIT];
	wire [1:0]  lna_req  = regs_ff[R_AGC][LNAG_LO +: 2];
	wire [3:0]  tmode    = regs_ff[R_TEST][TMODE_LO +: 4];
	wire [3:0]  pe_code  = regs_ff[R_OFSG][PE_LO +: 4];
	wire [11:0] ofs      = regs_ff[R_OFSG][OFS_LO +: 12];
	wire [3:0]  tgain    = regs_ff[R_OFSG][GAIN_LO +: 4];

	wire        det_en   = rx_mode && (setup == SETUP_SYNC_A || setup == SETUP_SYNC_B);
	wire        dm_lin   = dsel == DSEL_LIN;
	wire        dm_corr  = dsel == DSEL_CORR;

	// ----------------------------------------
	// readback validity
	// ----------------------------------------
	// rssi only in receive
	wire        v_rssi   = rx_mode;
	wire        v_afc    = rx_mode && (dm_lin || dm_corr);
	// adc off in tx by default
	wire        adc_on   = rx_mode ? !agc_on : adc_req;
	wire        rb_valid = (rb_sel == RSD_RB_AFC)  ? v_afc :
	                       (rb_sel == RSD_RB_RSSI) ? v_rssi :
	                       (rb_sel == RSD_RB_ADC)  ? adc_on : 1'b1;
	// invalid words read as zero so stale data is never mistaken
	wire [15:0] rb_word  = !rb_valid ? 16'h0000 :
	                       (rb_sel == RSD_RB_AFC)  ? afc_word :
	                       (rb_sel == RSD_RB_RSSI) ? rssi_word :
	                       (rb_sel == RSD_RB_ADC)  ? adc_word : cal_word;

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	wire [31:0] status   = {24'h000000, rb_valid, recen_ff, clock_output_pin_ff,
	                        cal_ff, adcpu_ff, det_en, int_lock_pin, rx_mode};
	wire        rd_st    = s_axi_araddr == ADDR_STATUS;
	wire        rd_rb    = s_axi_araddr == ADDR_RDBK;
	wire        rd_cfg   = s_axi_araddr == ADDR_CFG;
	wire        rd_map   = rd_st || rd_rb || rd_cfg;
	wire [31:0] rd_mux   = rd_st ? status : rd_rb ? {16'h0000, rb_word} : 32'h00000000;

	// ----------------------------------------
	// test dac datapath
	// ----------------------------------------
	// modes seven and ten
	wire        dac_on   = (tmode == TMODE_DAC) || (tmode == TMODE_DACOFS);
	wire        ofs_on   = tmode == TMODE_DACOFS;
	wire [15:0] dac_src  = dm_corr ? corr_filt : lin_filt;
	wire signed [31:0] ofs_diff = {{4{dac_src[15]}}, dac_src, 12'h000}
	                              - (ofs_on ? {20'h00000, ofs} : 32'h00000000);
	wire signed [47:0] gained   = 48'(ofs_diff) <<< tgain;
	wire [15:0] dac_in   = sat16(gained >>> 12);
	wire        rec_tick = recovery_clock && dac_on;
	wire        sdm_tick = rec_tick && (pe_cnt_ff == pe_code);
	wire        sdm_bit;

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	// stored pattern compare
	rsd_sync_det u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.det_en  (det_en),
		.bit_en  (rx_bit_en),
		.bit_in  (rx_bit),
		.pattern (sync_pat),
		.lock    (int_lock_pin)
	);

	rsd_sdm u_sdm (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.tick    (sdm_tick),
		.din     (dac_in),
		.bit_out (sdm_bit)
	);

	// ----------------------------------------
	// axi write channel
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end else if (clk_en) begin
			// take address and data in either order
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			// both present: commit and answer
			if (wr_fire) begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// partial strobes are refused: a config word only makes sense whole
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 16; i++) begin
				regs_ff[i] <= 32'h00000000;
			end
			regs_ff[R_AGC] <= AGC_RST;
		end else if (clk_en && wr_do) begin
			regs_ff[wr_sel] <= wdata_ff;
		end
	end

	// ----------------------------------------
	// axi read channel
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_mux;
				rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cal_ff   <= 1'b0;
			lna_ff   <= 2'h0;
			match_ff <= 1'b0;
			adcpu_ff <= 1'b0;
			recen_ff <= 1'b0;
			afcs_ff  <= 16'h0000;
		end else if (clk_en) begin
			cal_ff   <= wr_do && (wr_sel == R_CORR) && wdata_ff[CAL_BIT];
			lna_ff   <= (reduced && lna_req == LNA_TOP) ? LNA_TOP - 2'h1 : lna_req;
			match_ff <= regs_ff[R_PWR][MATCH_BIT];
			adcpu_ff <= adc_on;
			// divider of one or zero stops recovery
			recen_ff <= cdr_div > 8'h01;
			afcs_ff  <= regs_ff[R_AFC][AFCS_LO +: 16];
		end
	end

	assign filter_cal_start = cal_ff;
	assign lna_gain_code    = lna_ff;
	assign matching_select  = match_ff;
	assign adc_powered      = adcpu_ff;
	assign recovery_enable  = recen_ff;
	assign afc_scale        = afcs_ff;

	// ----------------------------------------
	// pulse stretch and pin drive
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pe_cnt_ff <= 4'h0;
			clock_output_pin_ff <= 1'b0;
		end else if (clk_en) begin
			if (sdm_tick) pe_cnt_ff <= 4'h0;
			else if (rec_tick) pe_cnt_ff <= pe_cnt_ff + 4'h1;
			clock_output_pin_ff <= dac_on && sdm_bit;
		end
	end

	assign clock_output_pin = clock_output_pin_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	cal_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && wr_do && wr_sel == R_CORR && wdata_ff[CAL_BIT] |=> filter_cal_start ##1 !filter_cal_start)
		else $error("calibration pulse missing");
	reduced_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && reduced ##1 clk_en && reduced |-> lna_gain_code != LNA_TOP)
		else $error("top gain while reduced");
	top_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && !reduced && lna_req == LNA_TOP |=> lna_gain_code == LNA_TOP)
		else $error("top gain withheld");
	match_reset_a: assert property (@(posedge sys_clk)
		!rst_b |=> !matching_select)
		else $error("matching select not cleared");
	rssi_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rb_sel == RSD_RB_RSSI && !rx_mode |-> !status[7] && rb_word == 16'h0000)
		else $error("rssi valid outside receive");
	afc_valid_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rb_sel == RSD_RB_AFC && rx_mode && !dm_lin && !dm_corr |-> !rb_valid)
		else $error("afc valid without demod");
	adc_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && !rx_mode && !adc_req |=> !adc_powered)
		else $error("adc on in transmit");
	dac_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && !dac_on ##1 clk_en && !dac_on |=> !clock_output_pin)
		else $error("clock pin driven while dac off");
	det_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && !det_en |=> !int_lock_pin)
		else $error("lock pin without detection");
	stretch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && rec_tick && pe_cnt_ff == pe_code |=> pe_cnt_ff == 4'h0)
		else $error("stretch count not restarted");
	bvalid_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
endmodule
`default_nettype wire

// >>> rsd_pkg.sv
/*
 * rsd_pkg: constants for the receive-side configuration bank.
 * Assumes 32-bit configuration words whose four low bits select a register.
 */
`default_nettype none
package rsd_pkg;
	// ----------------------------------------
	// bus map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CFG    = 8'h00; // config word, write only
	localparam logic [7:0] ADDR_STATUS = 8'h04; // block state
	localparam logic [7:0] ADDR_RDBK   = 8'h08; // selected readback word
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// register select codes
	// ----------------------------------------
	localparam logic [3:0] R_MODE  = 4'h0; // tx/rx
	localparam logic [3:0] R_RXCLK = 4'h3;
	localparam logic [3:0] R_DEMOD = 4'h4;
	localparam logic [3:0] R_SYNC  = 4'h5;
	localparam logic [3:0] R_CORR  = 4'h6;
	localparam logic [3:0] R_RDBK  = 4'h7;
	localparam logic [3:0] R_PWR   = 4'h8;
	localparam logic [3:0] R_AGC   = 4'h9;
	localparam logic [3:0] R_AFC   = 4'hb;
	localparam logic [3:0] R_TEST  = 4'hc;
	localparam logic [3:0] R_OFSG  = 4'hd;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int RX_BIT     = 27; // reg0, 1 = receive
	localparam int CDR_DIV_LO = 4;  // reg3, 8 bits
	localparam int SETUP_LO   = 23; // reg4, 3 bits
	localparam int DSEL_LO    = 4;  // reg4, 2 bits
	localparam int SYNC_LO    = 4;  // reg5, 24 bits
	localparam int CAL_BIT    = 19; // reg6
	localparam int RED_BIT    = 15; // reg6
	localparam int RBSEL_LO   = 4;  // reg7, 2 bits
	localparam int ADCPU_BIT  = 8;  // reg8
	localparam int MATCH_BIT  = 12; // reg8
	localparam int AGCLO_LO   = 4;  // reg9, 7 bits
	localparam int AGCHI_LO   = 11; // reg9, 7 bits
	localparam int AGCEN_BIT  = 18; // reg9
	localparam int LNAG_LO    = 19; // reg9, 2 bits
	localparam int AFCS_LO    = 4;  // reg11, 16 bits
	localparam int TMODE_LO   = 14; // reg12, 4 bits
	localparam int PE_LO      = 12; // reg13
	localparam int OFS_LO     = 16; // reg13, 12 bits
	localparam int GAIN_LO    = 28; // reg13, 4 bits
	// ----------------------------------------
	// codes and reset values
	// ----------------------------------------
	localparam logic [2:0] SETUP_SYNC_A = 3'h2;
	localparam logic [2:0] SETUP_SYNC_B = 3'h3;
	localparam logic [1:0] DSEL_LIN     = 2'h0;
	localparam logic [1:0] DSEL_CORR    = 2'h1;
	localparam logic [3:0] TMODE_DAC    = 4'h7;
	localparam logic [3:0] TMODE_DACOFS = 4'ha;
	localparam logic [1:0] LNA_TOP      = 2'h3; // gain of 30
	localparam logic [31:0] AGC_RST     = 32'h000231e9; // floor 30, ceiling 70
	localparam logic [3:0] SYNC_HOLD_BITS = 4'h9;
	typedef enum logic [1:0] {RSD_RB_AFC, RSD_RB_RSSI, RSD_RB_ADC, RSD_RB_CAL} rsd_rb_e;
endpackage
`default_nettype wire

// >>> rsd_sync_det.sv
/*
 * rsd_sync_det: 24-bit sync word matcher with a timed lock indication.
 * Assumes one received bit per bit_en pulse, msb of the word arriving first.
 */
`timescale 1ns/1ps
`default_nettype none
module rsd_sync_det import rsd_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        det_en,
	input  wire logic        bit_en,
	input  wire logic        bit_in,
	input  wire logic [23:0] pattern,
	output logic             lock
);
	logic [23:0] shift_ff;  // newest bit at lsb
	logic [3:0]  cnt_ff;    // bits seen since match
	wire  [23:0] nxt_shift = {shift_ff[22:0], bit_in};
	wire         hit       = det_en && bit_en && (nxt_shift == pattern);
	// ----------------------------------------
	// shift and lock timing
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			shift_ff <= 24'h000000;
			cnt_ff   <= 4'h0;
			lock     <= 1'b0;
		end else if (clk_en) begin
			if (bit_en) shift_ff <= nxt_shift;
			if (!det_en) begin
				lock <= 1'b0;
			end else if (hit) begin
				lock   <= 1'b1;
				cnt_ff <= 4'h0;
			end else if (lock && bit_en) begin
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff == SYNC_HOLD_BITS - 4'h1) lock <= 1'b0;
			end
		end
	end
	lock_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clk_en && lock && bit_en && !hit && cnt_ff == SYNC_HOLD_BITS - 4'h1 |=> !lock)
		else $error("lock held past nine bits");
endmodule
`default_nettype wire

// >>> rsd_sdm.sv
/*
 * rsd_sdm: second-order error-feedback sigma-delta, one bit out.
 * Assumes tick marks the recovery clock rate; din is signed 16-bit.
 */
`timescale 1ns/1ps
`default_nettype none
module rsd_sdm (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        tick,
	input  wire logic [15:0] din,
	output logic             bit_out
);
	logic signed [19:0] e1_ff; // last error
	logic signed [19:0] e2_ff; // error before that
	// v = x + 2e1 - e2, quantised to full scale
	wire signed [19:0] v = 20'(signed'(din)) + (e1_ff <<< 1) - e2_ff;
	wire signed [19:0] q = v[19] ? -20'sh08000 : 20'sh07fff;
	// ----------------------------------------
	// modulator state
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			e1_ff   <= 20'sh00000;
			e2_ff   <= 20'sh00000;
			bit_out <= 1'b0;
		end else if (clk_en && tick) begin
			e2_ff   <= e1_ff;
			e1_ff   <= v - q;
			bit_out <= !v[19];
		end
	end
endmodule
`default_nettype wire

// >>> rsd_tx_model.sv
/* rsd_tx_model: serial source standing in for the far transmitter.
 * assumes one clock with the bank; word is sampled on go. */
`timescale 1ns/1ps
`default_nettype none
module rsd_tx_model (
	input  wire logic        sys_clk,
	input  wire logic        go,
	input  wire logic [23:0] word,
	output logic             bit_o,
	output logic             bit_en
);
	logic [35:0] sh_ff = 36'h0; // word, then a fixed tail
	logic [7:0]  cnt_ff = 8'h0; // cycles left in frame
	always @(posedge sys_clk) begin
		if (go) begin
			sh_ff <= {word, 12'h5a3};
			cnt_ff <= 8'd144;
			bit_o <= ~bit_o;
			bit_en <= 1'b0;
		end else if (cnt_ff != 8'h0 && cnt_ff[1:0] == 2'h0) begin
			cnt_ff <= cnt_ff - 8'd1;
			bit_o <= sh_ff[35];
			bit_en <= 1'b1;
			sh_ff <= {sh_ff[34:0], 1'b0};
		end else begin
			if (cnt_ff != 8'h0)
				cnt_ff <= cnt_ff - 8'd1;
			// line wanders between strobes so stale data never looks valid
			bit_o <= ~bit_o;
			bit_en <= 1'b0;
		end
	end
	initial begin
		bit_o = 1'b0;
		bit_en = 1'b0;
	end
endmodule
`default_nettype wire

// >>> tb.sv
/* tb: self-checking bench for rsd_cfg_bank.
 * assumes the bank answers on AXI4-Lite and ticks come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module tb import rsd_pkg::*; ;
	logic        sys_clk = 0, rst_b = 0, clk_en = 1, go = 0, tick = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, seed = 32'h968ec47e;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp, lna;
	logic        awready, wready, bvalid, arready, rvalid, rx_bit, rx_bit_en;
	logic [23:0] pat = 0;
	logic [15:0] lin = 0, corr = 0, afc = 0, rssi = 0, adc = 0, cal = 0, afcs;
	logic        lock, pin, cal_p, mat, adcp, rec_en;
	logic [35:0] lkv = 0; // lock level seen at each strobe
	int          miscompares = 0, total_checks = 0, cyc = 0, ones = 0, cals = 0;
	localparam logic [31:0] RXW = 32'h1 << RX_BIT;
	// crystal value is a bench assumption only; any plausible figure works
	localparam longint CRYSTAL_FREQUENCY = 64'd10000000;
	localparam logic [15:0] AFC_COEF = 16'(((64'd500 << 24) + CRYSTAL_FREQUENCY / 2) / CRYSTAL_FREQUENCY);
	rsd_cfg_bank u_rsd_cfg_bank (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .lin_filt(lin), .corr_filt(corr),
		.recovery_clock(tick), .afc_word(afc), .rssi_word(rssi), .adc_word(adc),
		.cal_word(cal), .int_lock_pin(lock), .clock_output_pin(pin),
		.filter_cal_start(cal_p), .lna_gain_code(lna), .matching_select(mat),
		.adc_powered(adcp), .recovery_enable(rec_en), .afc_scale(afcs));
	rsd_tx_model u_rsd_tx_model (.sys_clk(sys_clk), .go(go), .word(pat),
		.bit_o(rx_bit), .bit_en(rx_bit_en));
	// ----------------------------------------
	// clock, monitors, timeout
	// ----------------------------------------
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		tick <= (cyc % 4) == 0;
		ones <= ones + pin;
		cals <= cals + cal_p;
		if (rx_bit_en)
			lkv <= {lkv[34:0], lock};
		// hang guard, far beyond the expected run
		if (cyc == 40000) begin
			miscompares++;
			final_report();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// strobe k of 36 lands at bit 36-k; high from match until the hold runs out
	function automatic logic [35:0] lk_exp(input logic on);
		lk_exp = 36'h0;
		for (int k = 25; k <= 24 + SYNC_HOLD_BITS; k++)
			lk_exp[36-k] = on;
	endfunction
	function automatic logic [31:0] rbs(input rsd_rb_e s);
		return {26'h0, s, R_RDBK};
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// bus master: readies sampled mid-cycle, acted on after the edge
	// ----------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ta, tw, tv;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(negedge sys_clk);
			ta = awready;
			tw = wready;
			tv = bvalid;
			r = bresp;
			@(posedge sys_clk);
			if (ta)
				awvalid <= 0;
			if (tw)
				wvalid <= 0;
			if (tv) begin
				bready <= 0;
				break;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tv;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(negedge sys_clk);
			ta = arready;
			tv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
			if (ta)
				arvalid <= 0;
			if (tv) begin
				rready <= 0;
				break;
			end
		end
	endtask
	task automatic w(input logic [31:0] d);
		logic [1:0] r;
		axw(ADDR_CFG, d, 4'hf, r);
		chk(r, RESP_OKAY);
	endtask
	// ----------------------------------------
	// scenario helpers
	// ----------------------------------------
	task automatic sync_run(input logic [31:0] r0, input logic [2:0] code, input logic [35:0] e);
		logic [23:0] p;
		seed = xs(seed);
		p = seed[23:0];
		pat <= p;
		w(r0);
		w({29'h0, code} << SETUP_LO | R_DEMOD);
		w({4'h0, p, R_SYNC});
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
		// frame length is fixed by the source model
		repeat (150) @(posedge sys_clk);
		chk(lkv, e);
	endtask
	task automatic rbk(input logic [31:0] r0, r4, r7, r8, input logic [15:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		w(r0);
		w(r4);
		w(r7);
		w(r8);
		axr(ADDR_RDBK, d, r);
		chk(d, {16'h0, e});
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          c0;
		seed = xs(seed);
		{rssi, afc} <= seed;
		seed = xs(seed);
		{adc, cal} <= seed;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1;
		@(posedge sys_clk);
		#1;
		chk(mat, 1'b0);
		chk(adcp, 1'b0);
		axw(ADDR_CFG, RXW, 4'h3, r);
		chk(r, RESP_SLVERR);
		axr(8'h0c, d, r);
		chk(r, RESP_SLVERR);
		for (int i = 0; i < 9; i++)
			sync_run(i < 8 ? RXW : 32'h0, i[2:0], lk_exp(i < 8 && i[2:1] == 2'h1));
		w(AGC_RST | 32'h3 << LNAG_LO);
		c0 = cals;
		w(32'h1 << CAL_BIT | 32'h1 << RED_BIT | R_CORR);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(lna, 2'h2);
		w(32'h1 << CAL_BIT | R_CORR);
		w(R_CORR);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(lna, LNA_TOP);
		chk(cals - c0, 2);
		rbk(RXW, R_DEMOD, rbs(RSD_RB_RSSI), R_PWR, rssi);
		rbk(R_MODE, R_DEMOD, rbs(RSD_RB_RSSI), R_PWR, 16'h0);
		rbk(RXW, R_DEMOD, rbs(RSD_RB_AFC), R_PWR, afc);
		rbk(RXW, 32'h2 << DSEL_LO | R_DEMOD, rbs(RSD_RB_AFC), R_PWR, 16'h0);
		rbk(RXW, R_DEMOD, rbs(RSD_RB_ADC), R_PWR, adc);
		w(AGC_RST | 32'h1 << AGCEN_BIT);
		rbk(RXW, R_DEMOD, rbs(RSD_RB_ADC), R_PWR, 16'h0);
		rbk(R_MODE, R_DEMOD, rbs(RSD_RB_ADC), R_PWR, 16'h0);
		rbk(R_MODE, R_DEMOD, rbs(RSD_RB_ADC), 32'h1 << ADCPU_BIT | R_PWR, adc);
		#1;
		chk(adcp, 1'b1);
		w(32'h1 << CDR_DIV_LO | R_RXCLK);
		#1;
		chk(rec_en, 1'b0);
		w(32'h2 << CDR_DIV_LO | R_RXCLK);
		#1;
		chk(rec_en, 1'b1);
		w({12'h000, AFC_COEF, R_AFC});
		#1;
		chk(afcs, AFC_COEF);
		// correlator path selected with large input, linear path opposite
		corr <= 16'h7000;
		lin <= 16'h9000;
		w({30'h0, DSEL_CORR} << DSEL_LO | R_DEMOD);
		for (int m = 0; m < 2; m++) begin
			w({28'h0, m == 0 ? TMODE_DAC : TMODE_DACOFS} << TMODE_LO | R_TEST);
			c0 = ones;
			repeat (400) @(posedge sys_clk);
			chk(ones - c0 > 280, 1);
		end
		// zero input, half-step offset, gain 2^15: quarter density expected
		corr <= 16'h0000;
		w(32'hf << GAIN_LO | 32'h800 << OFS_LO | R_OFSG);
		repeat (40) @(posedge sys_clk);
		c0 = ones;
		repeat (400) @(posedge sys_clk);
		chk((ones - c0) > 70 && (ones - c0) < 130, 1);
		w(R_TEST);
		repeat (4) @(posedge sys_clk);
		c0 = ones;
		repeat (100) @(posedge sys_clk);
		chk(ones - c0, 0);
		final_report();
	end
endmodule
`default_nettype wire
